// File: wdr_pkg.sv
package wdr_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_NMI = 8'h04;
	localparam logic [7:0] OFF_LOAD = 8'h08;
	localparam logic [7:0] OFF_SVC = 8'h0c;
	localparam logic [7:0] OFF_COUNT = 8'h10;
	localparam logic [7:0] OFF_BRST = 8'h14;
	localparam logic [7:0] OFF_STAT = 8'h18;
	localparam logic [7:0] OFF_MASK = 8'h1c;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_RSTEN_BIT = 1;
	localparam int BRST_BIT = 0;
	localparam int ST_NMI_BIT = 0;
	localparam int ST_EXP_BIT = 1;
	localparam logic [31:0] LOAD_RST = 32'hffff_ffff;
	localparam logic [23:0] NMI_RST = 24'h00_0000;
	localparam logic [31:0] SVC_KEY = 32'h0000_a5a5;
	localparam int SYS_CLK_MHZ = 100;
	localparam int EXP_HOLD_CYC = 16;
	localparam int POR_HOLD_CYC = 16;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {WDR_IDLE, WDR_RUN, WDR_EXPIRED} wdr_state_t;
endpackage : wdr_pkg

// File: wdr_top.sv
`timescale 1ns/1ns
module wdr_top (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic pci_bus_reset_in_n,
	input wire logic jtag_test_reset_in_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wd_nmi_out_n,
	output logic wd_expire_out_n,
	output logic board_reset_out_n,
	output logic host_reset_out_n,
	output logic irq
);
	logic aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] ctrl_q, ctrl_d;
	logic [23:0] nmi_threshold_q, nmi_threshold_d;
	logic [31:0] load_q, load_d, count_q, count_d;
	logic brst_q, brst_d;
	logic [1:0] stat_q, stat_d, mask_q, mask_d;
	wdr_pkg::wdr_state_t st_q, st_d;
	logic nmi_q, nmi_d, exp_q, exp_d, irq_q, irq_d;
	logic [4:0] hold_q, hold_d;
	logic [4:0] por_q, por_d;
	logic brd_q, brd_d, host_q, host_d;
	logic wr_go, svc_hit, src_any;
	logic [31:0] wr_val, ctrl_mrg, nmi_mrg;
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge
	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= wdr_pkg::OFF_MASK);
	endfunction : mapped
	always_comb begin
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (s_axi_awvalid && !aw_got_q) begin
			aw_got_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_got_q) begin
			w_got_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (wr_go) begin
			aw_got_d = 1'b0;
			w_got_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = mapped(awaddr_q) ? wdr_pkg::RESP_OKAY : wdr_pkg::RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (s_axi_arvalid && !rvalid_q) begin
			rvalid_d = 1'b1;
			rresp_d = mapped(s_axi_araddr) ? wdr_pkg::RESP_OKAY : wdr_pkg::RESP_SLVERR;
			case (s_axi_araddr)
				wdr_pkg::OFF_CTRL: rdata_d = {30'h0, ctrl_q};
				wdr_pkg::OFF_NMI: rdata_d = {8'h00, nmi_threshold_q};
				wdr_pkg::OFF_LOAD: rdata_d = load_q;
				wdr_pkg::OFF_COUNT: rdata_d = count_q;
				wdr_pkg::OFF_BRST: rdata_d = {31'h0, brst_q};
				wdr_pkg::OFF_STAT: rdata_d = {30'h0, stat_q};
				wdr_pkg::OFF_MASK: rdata_d = {30'h0, mask_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end
	// Write commits once both halves are held and no response is pending
	assign wr_go = aw_got_q && w_got_q && !bvalid_q;
	assign wr_val = merge(32'h0000_0000, wdata_q, wstrb_q);
	assign svc_hit = wr_go && awaddr_q == wdr_pkg::OFF_SVC && wdata_q == wdr_pkg::SVC_KEY;
	assign ctrl_mrg = merge({30'h0, ctrl_q}, wdata_q, wstrb_q);
	assign nmi_mrg = merge({8'h00, nmi_threshold_q}, wdata_q, wstrb_q);
	// Watchdog counter and outputs
	always_comb begin
		ctrl_d = ctrl_q;
		nmi_threshold_d = nmi_threshold_q;
		load_d = load_q;
		brst_d = brst_q;
		mask_d = mask_q;
		stat_d = stat_q;
		st_d = st_q;
		count_d = count_q;
		nmi_d = nmi_q;
		exp_d = exp_q;
		hold_d = hold_q;
		if (wr_go) begin
			case (awaddr_q)
				wdr_pkg::OFF_CTRL: ctrl_d = ctrl_mrg[1:0];
				wdr_pkg::OFF_NMI: nmi_threshold_d = nmi_mrg[23:0];
				wdr_pkg::OFF_LOAD: load_d = merge(load_q, wdata_q, wstrb_q);
				wdr_pkg::OFF_BRST: brst_d = wr_val[wdr_pkg::BRST_BIT];
				wdr_pkg::OFF_MASK: mask_d = wr_val[1:0];
				wdr_pkg::OFF_STAT: stat_d = stat_q & ~wr_val[1:0];
				default: ;
			endcase
		end
		case (st_q)
			wdr_pkg::WDR_IDLE: begin
				count_d = load_q;
				nmi_d = 1'b0;
				if (ctrl_q[wdr_pkg::CTRL_EN_BIT]) begin
					st_d = wdr_pkg::WDR_RUN;
				end
			end
			wdr_pkg::WDR_RUN: begin
				if (!ctrl_q[wdr_pkg::CTRL_EN_BIT]) begin
					st_d = wdr_pkg::WDR_IDLE;
				end else if (svc_hit) begin
					count_d = load_q;
					nmi_d = 1'b0;
				end else if (count_q == 32'h0000_0000) begin
					st_d = wdr_pkg::WDR_EXPIRED;
					exp_d = 1'b1;
					stat_d[wdr_pkg::ST_EXP_BIT] = 1'b1;
					if (nmi_threshold_q == 24'h00_0000) begin
						nmi_d = 1'b1;
						stat_d[wdr_pkg::ST_NMI_BIT] = 1'b1;
					end
				end else begin
					count_d = count_q - 32'h0000_0001;
					if (count_q[31:24] == 8'h00 && count_q[23:0] == nmi_threshold_q) begin
						nmi_d = 1'b1;
						stat_d[wdr_pkg::ST_NMI_BIT] = 1'b1;
					end
				end
			end
			wdr_pkg::WDR_EXPIRED: begin
				// Stays expired until disabled or the board is reset
				if (!ctrl_q[wdr_pkg::CTRL_EN_BIT]) begin
					st_d = wdr_pkg::WDR_IDLE;
					exp_d = 1'b0;
				end
			end
			default: st_d = wdr_pkg::WDR_IDLE;
		endcase
		// Expiry pulse kept for a fixed count once board reset starts
		if (hold_q != 5'd0) begin
			hold_d = hold_q - 5'd1;
		end
	end
	// Reset merge: enabled expiry, kept up through its hold since reset clears the enable
	assign src_any = (exp_q && (ctrl_q[wdr_pkg::CTRL_RSTEN_BIT] || hold_q != 5'd0))
			|| !pci_bus_reset_in_n || !jtag_test_reset_in_n || brst_q
			|| (por_q != 5'd0);
	always_comb begin
		por_d = (por_q != 5'd0) ? por_q - 5'd1 : por_q;
		brd_d = !src_any;
		host_d = !src_any;
		irq_d = |(stat_d & mask_q);
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			por_q <= 5'(wdr_pkg::POR_HOLD_CYC);
			brd_q <= 1'b0;
			host_q <= 1'b0;
			irq_q <= 1'b0;
		end else if (clk_en) begin
			por_q <= por_d;
			brd_q <= brd_d;
			host_q <= host_d;
			irq_q <= irq_d;
		end
	end
	// Onboard logic and the watchdog settings, counter and warning are reset by the merged source; status and mask keep their values
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'b00;
			rvalid_q <= 1'b0;
			rresp_q <= 2'b00;
			rdata_q <= 32'h0000_0000;
			mask_q <= 2'b00;
			stat_q <= 2'b00;
			exp_q <= 1'b0;
			hold_q <= 5'd0;
			ctrl_q <= 2'b00;
			nmi_threshold_q <= wdr_pkg::NMI_RST;
			load_q <= wdr_pkg::LOAD_RST;
			count_q <= wdr_pkg::LOAD_RST;
			brst_q <= 1'b0;
			st_q <= wdr_pkg::WDR_IDLE;
			nmi_q <= 1'b0;
		end else if (clk_en) begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			mask_q <= mask_d;
			stat_q <= stat_d;
			if (!brd_q) begin
				// Expiry held for the hold count; this edge already is its first cycle
				if (exp_q && hold_q == 5'd0 && st_q == wdr_pkg::WDR_EXPIRED) begin
					hold_q <= 5'(wdr_pkg::EXP_HOLD_CYC - 1);
					st_q <= wdr_pkg::WDR_IDLE;
				end else begin
					hold_q <= hold_d;
					exp_q <= (hold_d != 5'd0);
				end
				ctrl_q <= 2'b00;
				nmi_threshold_q <= wdr_pkg::NMI_RST;
				load_q <= wdr_pkg::LOAD_RST;
				count_q <= wdr_pkg::LOAD_RST;
				brst_q <= 1'b0;
				nmi_q <= 1'b0;
			end else begin
				exp_q <= exp_d;
				hold_q <= hold_d;
				ctrl_q <= ctrl_d;
				nmi_threshold_q <= nmi_threshold_d;
				load_q <= load_d;
				count_q <= count_d;
				brst_q <= brst_d;
				st_q <= st_d;
				nmi_q <= nmi_d;
			end
		end
	end
	assign s_axi_awready = !aw_got_q && clk_en;
	assign s_axi_wready = !w_got_q && clk_en;
	assign s_axi_arready = !rvalid_q && clk_en;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign wd_nmi_out_n = !nmi_q;
	assign wd_expire_out_n = !exp_q;
	assign board_reset_out_n = brd_q;
	assign host_reset_out_n = host_q;
	assign irq = irq_q;
	sequence s_expiry;
		st_q == wdr_pkg::WDR_RUN && count_q == 32'h0 && ctrl_q[0] && !svc_hit && brd_q;
	endsequence
	a_count_down: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_q == wdr_pkg::WDR_RUN && ctrl_q[0] && !svc_hit && count_q != 0 && brd_q && clk_en
		|=> count_q == $past(count_q) - 32'h1)
		else $error("count did not decrement");
	a_free_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_q == wdr_pkg::WDR_RUN && brd_q && clk_en && ctrl_q[0] |=> st_q != wdr_pkg::WDR_IDLE)
		else $error("enabled watchdog stopped");
	a_nmi_warn: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_q == wdr_pkg::WDR_RUN && ctrl_q[0] && !svc_hit && brd_q && clk_en
		&& count_q == {8'h00, nmi_threshold_q} |=> !wd_nmi_out_n)
		else $error("warning not raised at threshold");
	a_nmi_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(nmi_q) && mask_q[0] && clk_en |-> ##[0:1] irq)
		else $error("warning gave no interrupt");
	a_expire_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_expiry and clk_en |=> !wd_expire_out_n)
		else $error("expiry not asserted");
	a_expire_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && hold_q != 5'd0 |-> !wd_expire_out_n && !board_reset_out_n)
		else $error("expiry not held");
	a_expire_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
		exp_q && ctrl_q[1] && clk_en |=> !board_reset_out_n)
		else $error("expiry gave no board reset");
	a_expire_noreset: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && exp_q && !ctrl_q[1] && pci_bus_reset_in_n && jtag_test_reset_in_n && !brst_q
		&& por_q == 0 && hold_q == 5'd0 |=> board_reset_out_n)
		else $error("masked expiry reset board");
	a_src_pci: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && !pci_bus_reset_in_n |=> !board_reset_out_n)
		else $error("pci reset ignored");
	a_host_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en |=> host_reset_out_n == board_reset_out_n)
		else $error("host reset differs from board reset");
	a_service: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && svc_hit && st_q == wdr_pkg::WDR_RUN && ctrl_q[0] && brd_q
		|=> count_q == $past(load_q))
		else $error("service did not reload");
endmodule : wdr_top

// File: wdr_far_end.sv
`timescale 1ns/1ns
// Interrupt input and reset logic on the far side of the watchdog
module wdr_far_end (
	input wire logic clk_sys,
	input wire logic int_ack,
	input wire logic wd_nmi_out_n,
	input wire logic wd_expire_out_n,
	input wire logic board_reset_out_n,
	output logic int_pend_q,
	output logic [7:0] hold_q
);
	logic int_pend_d;
	logic [7:0] hold_d;
	always_comb begin
		// Level input, so a held warning keeps re-raising it, even after an ack, until the warning drops
		int_pend_d = (int_pend_q && !int_ack) || !wd_nmi_out_n;
		hold_d = hold_q;
		if (int_ack) begin
			hold_d = 8'h00;
		end else if (!wd_expire_out_n && !board_reset_out_n) begin
			hold_d = hold_q + 8'h01;
		end
	end
	always_ff @(posedge clk_sys) begin
		int_pend_q <= int_pend_d;
		hold_q <= hold_d;
	end
endmodule : wdr_far_end

// File: tb_watchdog_and_board_reset.sv
`timescale 1ns/1ns
module tb_watchdog_and_board_reset;
	logic clk_sys, rst_n, clk_en, pci_bus_reset_in_n, jtag_test_reset_in_n, int_ack;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, c1, c2;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic wd_nmi_out_n, wd_expire_out_n, board_reset_out_n, host_reset_out_n, irq, int_pend_q;
	logic [7:0] hold_q;
	int error_cnt, checked, cyc;
	wdr_top uut (.clk_sys, .rst_n, .clk_en, .pci_bus_reset_in_n, .jtag_test_reset_in_n,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .wd_nmi_out_n, .wd_expire_out_n,
		.board_reset_out_n, .host_reset_out_n, .irq);
	wdr_far_end far (.clk_sys, .int_ack, .wd_nmi_out_n, .wd_expire_out_n,
		.board_reset_out_n, .int_pend_q, .hold_q);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run
	// Ceiling well above the less than one thousand cycles the sequence needs
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Ready is looked at on the falling edge, so the handshake edge is free of races
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge clk_sys);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge clk_sys);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
		end while (tb !== 1'b1);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic ta, tr;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge clk_sys);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge clk_sys);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
		end while (tr !== 1'b1);
	endtask : rd
	task automatic wait_board;
		while (board_reset_out_n !== 1'b1) @(negedge clk_sys);
		repeat (2) @(posedge clk_sys);
	endtask : wait_board
	initial begin
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{clk_en, pci_bus_reset_in_n, jtag_test_reset_in_n, int_ack} = 4'hf;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		cyc = 0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		int_ack <= 1'b0;
		wait_board();
		rd(wdr_pkg::OFF_LOAD, c1);
		chk(c1, wdr_pkg::LOAD_RST);
		rd(8'h20, c1);
		chk(c1, 32'h0000_0000);
		chk({30'h0, rsp}, {30'h0, wdr_pkg::RESP_SLVERR});
		$display("test reset values done");
		wr(wdr_pkg::OFF_LOAD, 32'h0000_0200);
		wr(wdr_pkg::OFF_NMI, 32'h0000_0040);
		wr(wdr_pkg::OFF_MASK, 32'h0000_0001);
		wr(wdr_pkg::OFF_CTRL, 32'h0000_0001);
		rd(wdr_pkg::OFF_COUNT, c1);
		rd(wdr_pkg::OFF_COUNT, c2);
		chk({31'h0, c2 < c1 && c1 <= 32'h0000_0200}, 32'h1);
		wr(wdr_pkg::OFF_SVC, wdr_pkg::SVC_KEY);
		rd(wdr_pkg::OFF_COUNT, c1);
		chk({31'h0, c1 > c2}, 32'h1);
		wr(wdr_pkg::OFF_SVC, 32'h0000_0000);
		rd(wdr_pkg::OFF_COUNT, c2);
		chk({31'h0, c2 < c1}, 32'h1);
		while (wd_nmi_out_n !== 1'b0) @(negedge clk_sys);
		chk({31'h0, wd_expire_out_n}, 32'h1);
		repeat (2) @(negedge clk_sys);
		chk({30'h0, irq, int_pend_q}, 32'h3);
		while (wd_expire_out_n !== 1'b0) @(negedge clk_sys);
		rd(wdr_pkg::OFF_COUNT, c1);
		chk(c1, 32'h0000_0000);
		chk({31'h0, board_reset_out_n}, 32'h1);
		wr(wdr_pkg::OFF_MASK, 32'h0000_0000);
		wr(wdr_pkg::OFF_CTRL, 32'h0000_0000);
		wr(wdr_pkg::OFF_STAT, 32'h0000_0003);
		rd(wdr_pkg::OFF_STAT, c1);
		chk({27'h0, c1[1:0], irq, wd_nmi_out_n, wd_expire_out_n}, 32'h0000_0003);
		$display("test warning and expiry done");
		wr(wdr_pkg::OFF_LOAD, 32'h0000_0030);
		wr(wdr_pkg::OFF_CTRL, 32'h0000_0003);
		while (wd_expire_out_n !== 1'b0) @(negedge clk_sys);
		repeat (2) @(negedge clk_sys);
		chk({30'h0, board_reset_out_n, host_reset_out_n}, 32'h0);
		wait_board();
		chk({24'h0, hold_q}, wdr_pkg::EXP_HOLD_CYC);
		chk({31'h0, wd_expire_out_n}, 32'h1);
		rd(wdr_pkg::OFF_CTRL, c1);
		chk(c1, 32'h0000_0000);
		$display("test expiry reset done");
		wr(wdr_pkg::OFF_LOAD, 32'h0000_0077);
		wr(wdr_pkg::OFF_BRST, 32'h0000_0001);
		// Software reset clears its own bit, so the board reset lasts two cycles
		@(negedge clk_sys);
		chk({30'h0, board_reset_out_n, host_reset_out_n}, 32'h0);
		wait_board();
		rd(wdr_pkg::OFF_LOAD, c1);
		chk(c1, wdr_pkg::LOAD_RST);
		for (int s = 0; s < 2; s++) begin
			@(posedge clk_sys);
			pci_bus_reset_in_n <= s[0];
			jtag_test_reset_in_n <= !s[0];
			repeat (3) @(negedge clk_sys);
			chk({30'h0, board_reset_out_n, host_reset_out_n}, 32'h0);
			@(posedge clk_sys);
			{pci_bus_reset_in_n, jtag_test_reset_in_n} <= 2'b11;
			wait_board();
		end
		$display("test reset sources done");
		complete_run();
	end
endmodule : tb_watchdog_and_board_reset
